// [sar_readout_port.sv]
/*
  serial readout port of an 18-bit sar converter: strobe capture,
  conversion timing, self-clocked and echoed-clock framing, static pins.
  assumes the host bursts the read clock with whole frames only and that
  the sar core presents its code on i_sar_code in the core clock domain.
*/
// What this block does
// - echo pin grounded selects self-clocked mode
// - self-clocked: header 10 before 18 bits
// - self-clocked: leading zero after previous frame
// - echo pin not grounded selects echoed mode
// - echoed mode: echo clock copies read clock
// - echoed mode: data changes on falling edge
// - each read-clock falling edge shifts next bit
// - bandwidth pin low wide, high narrow
// - common-mode output only while enable high
// - strobe rising edge while idle samples, starts conversion
// - strobe pins: cmos or differential pair
// - result msb first, two's complement
module sar_readout_port
  import sar_readout_pkg::*;
(
  // core clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // link clock from host
  input wire logic i_read_clk,
  // pins
  input wire logic i_conversion_strobe_pos,
  input wire logic i_conversion_strobe_neg,
  input wire logic i_echo_clk_pos_grounded,
  input wire logic i_bandwidth_select,
  input wire logic i_common_mode_out_enable,
  input wire logic i_ref_buffer_disable,
  // sar core
  input wire logic [CODE_W-1:0] i_sar_code,
  // register port
  input wire logic [ADDR_W-1:0] i_reg_addr,
  input wire logic [DATA_W-1:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [DATA_W-1:0] o_reg_rdata,
  // analog controls
  output logic o_sample_now,
  output logic o_bw_narrow,
  output logic o_common_mode_voltage_out_en,
  output logic o_ref_buffer_en,
  // serial link
  output logic o_serial_data,
  output logic o_echo_clock_out_pos,
  output logic o_echo_clock_out_neg
);

  // self-clocked: header 10, trailing zero; echoed: 18 bits only
  // frame bit for a given falling-edge index
  function automatic logic frame_bit(input frame_s f, input logic [CNT_W-1:0] idx);
    logic b;
    b = 1'b0;
    if (f.self_mode) begin
      if (idx == 5'h00) begin
        b = 1'b1;
      end else if (idx >= HDR_BITS && idx < HDR_BITS + 5'(CODE_W)) begin
        b = f.code[5'(CODE_W - 1) + HDR_BITS - idx];
      end
    end else if (idx < 5'(CODE_W)) begin
      b = f.code[5'(CODE_W - 1) - idx];
    end
    return b;
  endfunction

  // pin synchronisers and ack toggle crossing
  logic [PIN_N-1:0] pin_s1_r, pin_s2_r;
  logic ack_s1_r, ack_s2_r, ack_s3_r;
  logic frame_done_tgl_r;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      ack_s3_r <= 1'b0;
    end else begin
      pin_s1_r <= {i_ref_buffer_disable, i_common_mode_out_enable, i_bandwidth_select,
                   i_echo_clk_pos_grounded, i_conversion_strobe_neg, i_conversion_strobe_pos};
      pin_s2_r <= pin_s1_r;
      ack_s1_r <= frame_done_tgl_r;
      ack_s2_r <= ack_s1_r;
      ack_s3_r <= ack_s2_r;
    end
  end

  logic cmos_strobe, strobe_lvl, self_mode_pin, frame_read;
  assign cmos_strobe = ~pin_s2_r[PIN_STROBE_NEG];
  assign strobe_lvl = cmos_strobe ? pin_s2_r[PIN_STROBE_POS]
                                  : (pin_s2_r[PIN_STROBE_POS] & ~pin_s2_r[PIN_STROBE_NEG]);
  assign self_mode_pin = pin_s2_r[PIN_ECHO_GND];
  assign frame_read = ack_s2_r ^ ack_s3_r;

  // conversion and register state
  conv_state_e st_r, st_nxt;
  logic strobe_prev_r, strobe_prev_nxt;
  logic [3:0] cyc_r, cyc_nxt;
  logic [CODE_W-1:0] held_r, held_nxt;
  frame_s frame_r, frame_nxt;
  logic pending_r, pending_nxt;
  logic overrun_r, overrun_nxt;
  logic [DATA_W-1:0] ctrl_r, ctrl_nxt;
  logic [CODE_W-1:0] pattern_r, pattern_nxt;
  logic [DATA_W-1:0] count_r, count_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic sample_r, sample_nxt;
  logic bw_r, bw_nxt, cm_r, cm_nxt, refbuf_r, refbuf_nxt;
  logic done;

  assign done = (st_r == ST_CONVERT) && (cyc_r == 4'(CONV_CYC - 1));

  always_comb begin
    st_nxt = st_r;
    strobe_prev_nxt = strobe_lvl;
    cyc_nxt = cyc_r;
    held_nxt = held_r;
    frame_nxt = frame_r;
    pending_nxt = pending_r;
    overrun_nxt = overrun_r;
    ctrl_nxt = ctrl_r;
    pattern_nxt = pattern_r;
    count_nxt = count_r;
    rdata_nxt = '0;
    sample_nxt = 1'b0;
    bw_nxt = pin_s2_r[PIN_BW];
    cm_nxt = pin_s2_r[PIN_CM];
    refbuf_nxt = ~pin_s2_r[PIN_REFDIS];
    if (frame_read) begin
      pending_nxt = 1'b0;
    end
    case (st_r)
      ST_IDLE: begin
        if (strobe_lvl && !strobe_prev_r) begin
          st_nxt = ST_CONVERT;
          cyc_nxt = '0;
          sample_nxt = 1'b1;
          held_nxt = ctrl_r[CTRL_PATTERN_BIT] ? pattern_r : i_sar_code;
        end
      end
      ST_CONVERT: begin
        cyc_nxt = cyc_r + 4'h1;
        if (done) begin
          st_nxt = ST_IDLE;
          // two's complement code, msb sent first
          frame_nxt.code = held_r;
          frame_nxt.self_mode = self_mode_pin;
          count_nxt = count_r + 32'h0000_0001;
          pending_nxt = 1'b1;
          // a new frame over an unread one is flagged; set beats clear
          if (pending_r && !frame_read) begin
            overrun_nxt = 1'b1;
          end
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    if (i_reg_wr) begin
      if (i_reg_addr == OFS_CTRL) begin
        ctrl_nxt = {31'h0000_0000, i_reg_wdata[CTRL_PATTERN_BIT]};
      end else if (i_reg_addr == OFS_PATTERN) begin
        pattern_nxt = i_reg_wdata[CODE_W-1:0];
      end else if (i_reg_addr == OFS_STATUS && i_reg_wdata[STAT_OVERRUN_BIT]
                   && !(done && pending_r && !frame_read)) begin
        overrun_nxt = 1'b0;
      end
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        OFS_CTRL: rdata_nxt = ctrl_r;
        OFS_PATTERN: rdata_nxt = {14'h0000, pattern_r};
        OFS_STATUS: begin
          rdata_nxt[STAT_SELF_BIT] = frame_r.self_mode;
          rdata_nxt[STAT_BUSY_BIT] = (st_r == ST_CONVERT);
          rdata_nxt[STAT_OVERRUN_BIT] = overrun_r;
          rdata_nxt[STAT_PENDING_BIT] = pending_r;
        end
        OFS_RESULT: rdata_nxt = {14'h0000, frame_r.code};
        OFS_COUNT: rdata_nxt = count_r;
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_r <= ST_IDLE;
      strobe_prev_r <= 1'b0;
      cyc_r <= '0;
      held_r <= '0;
      frame_r <= '0;
      pending_r <= 1'b0;
      overrun_r <= 1'b0;
      ctrl_r <= CTRL_RST;
      pattern_r <= PATTERN_RST;
      count_r <= '0;
      rdata_r <= '0;
      sample_r <= 1'b0;
      bw_r <= 1'b0;
      cm_r <= 1'b0;
      refbuf_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      strobe_prev_r <= strobe_prev_nxt;
      cyc_r <= cyc_nxt;
      held_r <= held_nxt;
      frame_r <= frame_nxt;
      pending_r <= pending_nxt;
      overrun_r <= overrun_nxt;
      ctrl_r <= ctrl_nxt;
      pattern_r <= pattern_nxt;
      count_r <= count_nxt;
      rdata_r <= rdata_nxt;
      sample_r <= sample_nxt;
      bw_r <= bw_nxt;
      cm_r <= cm_nxt;
      refbuf_r <= refbuf_nxt;
    end
  end

  assign o_reg_rdata = rdata_r;
  assign o_sample_now = sample_r;
  assign o_bw_narrow = bw_r;
  assign o_common_mode_voltage_out_en = cm_r;
  assign o_ref_buffer_en = refbuf_r;

  // link domain: frame_r is quasi-static here, it only changes at the end
  // of a conversion while the host holds the read clock still
  logic [CNT_W-1:0] bit_cnt_r, bit_cnt_nxt, frame_len;
  logic data_r, data_nxt;
  logic frame_done_tgl_nxt;

  assign frame_len = frame_r.self_mode ? SELF_FRAME_BITS : ECHO_FRAME_BITS;

  always_comb begin
    data_nxt = frame_bit(frame_r, bit_cnt_r);
    bit_cnt_nxt = bit_cnt_r + 5'h01;
    frame_done_tgl_nxt = frame_done_tgl_r;
    // counter wraps on the frame's last edge
    if (bit_cnt_r == frame_len - 5'h01) begin
      bit_cnt_nxt = '0;
      frame_done_tgl_nxt = ~frame_done_tgl_r;
    end
  end

  always_ff @(negedge i_read_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bit_cnt_r <= '0;
      data_r <= 1'b0;
      frame_done_tgl_r <= 1'b0;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
      data_r <= data_nxt;
      frame_done_tgl_r <= frame_done_tgl_nxt;
    end
  end

  assign o_serial_data = data_r;
  // echo clock is a gated copy; a flop cannot reproduce a clock
  assign o_echo_clock_out_pos = i_read_clk & ~frame_r.self_mode;
  assign o_echo_clock_out_neg = ~i_read_clk & ~frame_r.self_mode;

  AST_HEADER_ONE: assert property (@(negedge i_read_clk) disable iff (i_sys_rst)
    (frame_r.self_mode && bit_cnt_r == 5'h00) |=> o_serial_data == 1'b1)
    else $error("header first bit not one");

  AST_HEADER_ZERO: assert property (@(negedge i_read_clk) disable iff (i_sys_rst)
    (frame_r.self_mode && bit_cnt_r == 5'h01) |=> o_serial_data == 1'b0)
    else $error("header second bit not zero");

  AST_LEAD_ZERO: assert property (@(negedge i_read_clk) disable iff (i_sys_rst)
    (frame_r.self_mode && bit_cnt_r == 5'h14) |=> (o_serial_data == 1'b0 && bit_cnt_r == 5'h00))
    else $error("leading zero missing at frame end");

  AST_MSB_FIRST: assert property (@(negedge i_read_clk) disable iff (i_sys_rst)
    (!frame_r.self_mode && bit_cnt_r == 5'h00) |=> o_serial_data == $past(frame_r.code[17]))
    else $error("echoed frame did not start with msb");

  AST_SHIFT_LSB: assert property (@(negedge i_read_clk) disable iff (i_sys_rst)
    (!frame_r.self_mode && bit_cnt_r == 5'h11) |=> (o_serial_data == $past(frame_r.code[0])
    && bit_cnt_r == 5'h00))
    else $error("echoed frame lsb or wrap wrong");

  AST_ECHO_COPY: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    !frame_r.self_mode |-> o_echo_clock_out_pos == i_read_clk)
    else $error("echo clock not a copy in echoed mode");

  AST_SELF_QUIET: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    frame_r.self_mode |-> (!o_echo_clock_out_pos && !o_echo_clock_out_neg))
    else $error("echo clock active in self-clocked mode");

  sequence s_strobe_rise;
    strobe_lvl && !strobe_prev_r && st_r == ST_IDLE;
  endsequence

  sequence s_conv_done;
    ##5 (pending_r && frame_r.code == $past(held_r));
  endsequence

  AST_CONV_START: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    s_strobe_rise |=> (o_sample_now && st_r == ST_CONVERT) ##0 s_conv_done)
    else $error("strobe edge did not start a timed conversion");

  AST_MODE_LATCH: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (done && !self_mode_pin) |=> !frame_r.self_mode)
    else $error("echo mode not taken from pin");

  AST_BW_PIN: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    $rose(pin_s2_r[PIN_BW]) |=> o_bw_narrow ##1 $stable(o_bw_narrow) || !pin_s2_r[PIN_BW])
    else $error("bandwidth output does not follow pin");

  AST_CM_PIN: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    !pin_s2_r[PIN_CM] |=> !o_common_mode_voltage_out_en)
    else $error("common-mode output on with pin low");

endmodule

// [sar_readout_pkg.sv]
/*
  constants, offsets and frame type shared by the serial readout port.
  assumes a 25 MHz core clock and a bursted read clock from the host.
*/
package sar_readout_pkg;
  localparam int CODE_W = 18;
  localparam int CNT_W = 5;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // frame lengths in read-clock falling edges
  localparam logic [CNT_W-1:0] SELF_FRAME_BITS = 5'h15;
  localparam logic [CNT_W-1:0] ECHO_FRAME_BITS = 5'h12;
  localparam logic [CNT_W-1:0] HDR_BITS = 5'h02;
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PATTERN = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h10;
  // field positions
  localparam int CTRL_PATTERN_BIT = 0;
  localparam int STAT_SELF_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_OVERRUN_BIT = 2;
  localparam int STAT_PENDING_BIT = 3;
  // reset values
  localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;
  localparam logic [CODE_W-1:0] PATTERN_RST = 18'h0_0000;
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int CONV_TIME_NS = 200;
  localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // pin synchroniser slots
  localparam int PIN_STROBE_POS = 0;
  localparam int PIN_STROBE_NEG = 1;
  localparam int PIN_ECHO_GND = 2;
  localparam int PIN_BW = 3;
  localparam int PIN_CM = 4;
  localparam int PIN_REFDIS = 5;
  localparam int PIN_N = 6;

  typedef enum logic [0:0] {ST_IDLE, ST_CONVERT} conv_state_e;

  typedef struct packed {
    logic self_mode;
    logic [CODE_W-1:0] code;
  } frame_s;
endpackage

// [sar_host_model.sv]
/*
  behavioural host at the far side of the serial link: bursts the read
  clock, captures one frame and reports the aligned 18-bit word.
  assumes the bench raises i_go only once the frame is pending.
*/
module sar_host_model (
  // burst control
  input wire logic i_go,
  input wire logic i_self,
  // link pins
  input wire logic i_data,
  input wire logic i_echo,
  output logic o_read_clk,
  // capture
  output logic [17:0] o_word,
  output logic o_hdr_ok,
  output logic o_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [20:0] bits_r;
  integer k, n, h;
  initial begin
    o_read_clk = 1'b1;
    o_done = 1'b0;
    o_word = 18'h0_0000;
    o_hdr_ok = 1'b0;
  end
  always @(posedge i_go) begin
    n = i_self ? 21 : 18;
    #17;
    for (k = 0; k < n; k++) begin
      o_read_clk = 1'b0;
      #32 o_read_clk = 1'b1;
      // take bit just after rising edge
      #1 bits_r[k] = (i_self || i_echo === 1'b1) ? i_data : 1'bx;
      #31;
    end
    // align on first one of header
    h = 0;
    while (i_self && h < 2 && bits_r[h] !== 1'b1) h++;
    for (k = 0; k < 18; k++) o_word[17-k] = bits_r[k + (i_self ? h + 2 : 0)];
    o_hdr_ok = !i_self || (bits_r[0] === 1'b1 && bits_r[1] === 1'b0 && bits_r[20] === 1'b0);
    o_done = 1'b1;
  end
  always @(negedge i_go) o_done = 1'b0;
endmodule

// [test_sar_readout_port.sv]
/*
  self-checking bench for the serial readout port: pins, registers,
  conversions in both link modes, pattern source and refused strobes.
  assumes the host model of sar_host_model.sv on the link side.
*/
module test_sar_readout_port import sar_readout_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, strb_p = 0, strb_n = 0, gnd = 1, bw = 0, cm = 0, rdis = 0;
  logic go = 0, wr = 0, rd = 0, dbl = 0;
  logic [CODE_W-1:0] code = 0;
  logic [ADDR_W-1:0] addr = 0;
  logic [DATA_W-1:0] wdata = 0, rdata, v, t;
  logic samp, bwn, cme, rbe, sd, ep, en, rclk, done, hok;
  logic [17:0] word;
  logic [31:0] exp_q[$];
  integer n_fail = 0, n_checks = 0, n_samp = 0, cyc = 0, i, seed = 32'he44d3dd4;
  initial forever #20 clk = ~clk;
  sar_readout_port sar_readout_port_inst (.i_ref_clk(clk), .i_sys_rst(rst), .i_read_clk(rclk),
    .i_conversion_strobe_pos(strb_p), .i_conversion_strobe_neg(strb_n),
    .i_echo_clk_pos_grounded(gnd),
    .i_bandwidth_select(bw), .i_common_mode_out_enable(cm), .i_ref_buffer_disable(rdis),
    .i_sar_code(code), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .o_sample_now(samp), .o_bw_narrow(bwn),
    .o_common_mode_voltage_out_en(cme), .o_ref_buffer_en(rbe), .o_serial_data(sd),
    .o_echo_clock_out_pos(ep), .o_echo_clock_out_neg(en));
  sar_host_model sar_host_model_inst (.i_go(go), .i_self(gnd), .i_data(sd), .i_echo(ep),
    .o_read_clk(rclk), .o_word(word), .o_hdr_ok(hok), .o_done(done));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 d = rdata;
  endtask
  task automatic conv(input logic [17:0] c, input logic [17:0] e, input logic lvds,
    input logic self);
    logic [31:0] s;
    integer k;
    @(posedge clk);
    gnd <= self;
    code <= c;
    strb_n <= lvds;
    repeat (3) @(posedge clk);
    // strobe as cmos or as a pair
    strb_p <= 1;
    strb_n <= 0;
    repeat (2) @(posedge clk);
    if (dbl) begin
      strb_p <= 0;
      strb_n <= lvds;
      repeat (2) @(posedge clk);
      strb_p <= 1;
      strb_n <= 0;
      repeat (2) @(posedge clk);
    end
    strb_p <= 0;
    strb_n <= lvds;
    s = 0;
    for (k = 0; k < 30 && s[STAT_PENDING_BIT] !== 1'b1; k++) reg_rd(OFS_STATUS, s);
    chk("pending", 1, s[STAT_PENDING_BIT]);
    chk("self_bit", self, s[STAT_SELF_BIT]);
    reg_rd(OFS_RESULT, s);
    chk("result", e, s);
    if (self) chk("lead_zero", 0, sd);
    exp_q.push_back(e);
    @(posedge clk);
    go <= 1;
    for (k = 0; k < 200 && done !== 1'b1; k++) @(posedge clk);
    chk("done", 1, done);
    go <= 0;
    repeat (8) @(posedge clk);
  endtask
  always @(posedge done) begin
    #1 chk("frame", exp_q.pop_front(), word);
    chk("header", 1, hok);
  end
  always @(rclk) if (go) begin
    #2 chk("echo_pos", !gnd & rclk, ep);
    chk("echo_neg", !gnd & !rclk, en);
  end
  always @(posedge clk) begin
    if (samp === 1'b1) n_samp++;
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (exp_q.size() != 0) n_fail++;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    repeat (3) @(posedge clk);
    for (i = 0; i < 8; i++) begin
      {bw, cm, rdis} <= i[2:0];
      repeat (5) @(posedge clk);
      chk("bw", bw, bwn);
      chk("cm", cm, cme);
      chk("refbuf", !rdis, rbe);
    end
    $display("test pins done");
    reg_rd(OFS_CTRL, v);
    chk("ctrl_rst", CTRL_RST, v);
    reg_rd(OFS_PATTERN, v);
    chk("pattern_rst", PATTERN_RST, v);
    reg_rd(8'h14, v);
    chk("unmapped", 0, v);
    $display("test regs done");
    // self-clocked first, so the leading zero is known
    for (i = 0; i < 6; i++) begin
      v = $random(seed);
      conv(v[17:0], v[17:0], i[0], i < 3);
    end
    $display("test modes done");
    v = $random(seed);
    reg_wr(OFS_PATTERN, v & 32'h0003_FFFF);
    reg_rd(OFS_PATTERN, t);
    chk("pattern", v & 32'h0003_FFFF, t);
    reg_wr(OFS_CTRL, 32'h0000_0001);
    conv(18'h3_FFFF, v[17:0], 1'b0, 1'b0);
    reg_wr(OFS_CTRL, 32'h0000_0000);
    $display("test pattern done");
    dbl = 1;
    conv(18'h2_0000, 18'h2_0000, 1'b0, 1'b0);
    dbl = 0;
    // two frames with no burst between: the second one overruns
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      strb_p <= 1;
      repeat (2) @(posedge clk);
      strb_p <= 0;
      repeat (10) @(posedge clk);
    end
    reg_rd(OFS_STATUS, v);
    chk("overrun", 1, v[STAT_OVERRUN_BIT]);
    reg_wr(OFS_STATUS, 32'h0000_0004);
    reg_rd(OFS_STATUS, v);
    chk("overrun_clr", 0, v[STAT_OVERRUN_BIT]);
    chk("samples", 10, n_samp);
    reg_rd(OFS_COUNT, v);
    chk("count", 10, v);
    $display("test busy done");
    wrap_up();
  end
endmodule
